/* logic/fsec_event_error_ctrl.sv */
// Functional notes
// - Force write pulses chosen events one cycle
// - Two fail wires, any flags on either
// - Fail inputs synchronised, rising edge sets flag
// - Software can set or clear raw flags
// - Two masks gate flags; raw, masked readable
// - Bit0 system resync, not first sync
// - Bit1 radio resync, not first sync
// - Bit2 daytime resync, serial only, not first
// - Bits3-5 update timeouts, serial only
// - Bit6 checksum fail, serial only
// - Bit7 bit width fail, serial only
// - Bit8 reserved kind, serial, not discarded
// - Bit9 spare kind, serial, not discarded
// - Bit10 unexpected kind, serial, not discarded
// - Bits11-13 kind flags, serial, not discarded
// - Bit14 daytime counter wrap
// - Masked fail pulses wire once, then blocks
// - Rearm write re-evaluates, pulses if pending
// - Interrupt set and clear strobes per wire
// - Suspend: partial or full halt by control
// - Thirty-bit emulation mask selects halted events
`timescale 1ns/10ps
`default_nettype none
module fsec_event_error_ctrl import fsec_pkg::*; (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire fsec_fail_t   fail_in,
    input  wire logic         serial_sync_mode,
    input  wire logic         msg_discarded,
    input  wire logic [29:0]  gen_events,
    input  wire fsec_force_t  event_force_register,
    input  wire fsec_bitcmd_t raw_cmd,
    input  wire fsec_bitcmd_t mask0_cmd,
    input  wire fsec_bitcmd_t mask1_cmd,
    input  wire logic [1:0]   interrupt_rearm_register,
    input  wire logic [1:0]   int_set,
    input  wire logic [1:0]   int_clr,
    input  wire fsec_emu_t    emulation_control_register,
    input  wire logic [29:0]  emulation_event_mask,
    input  wire logic         debug_suspend_input,
    output logic      [29:0]  frame_events,
    output logic      [1:0]   fail_wire,
    output logic      [14:0]  raw_fail_flags,
    output logic      [14:0]  masked_stat0,
    output logic      [14:0]  masked_stat1,
    output logic      [14:0]  mask0_state,
    output logic      [14:0]  mask1_state,
    output logic      [1:0]   int_pending,
    output logic              partial_event_halt,
    output logic              timers_halt
);
    // Qualifiers share the fail synchroniser so they stay aligned with it
    localparam int SW = FSEC_FAIL_W + FSEC_QUAL_W;

    // Set wins over clear on every flag group
    // so an edge that meets a clear is never lost
    function automatic logic [14:0] fsec_apply(
        input logic [14:0]  cur,
        input fsec_bitcmd_t cmd,
        input logic [14:0]  hw_set
    );
        logic [14:0] clr_bits;
        logic [14:0] set_bits;
        clr_bits = cmd.clr ? cmd.bits : 15'h0000;
        set_bits = cmd.set ? cmd.bits : 15'h0000;
        return (cur & ~clr_bits) | set_bits | hw_set;
    endfunction

    // Aggregate of one wire's masked sources
    function automatic logic fsec_any_masked(
        input logic [14:0] raw,
        input logic [14:0] mask
    );
        return |(raw & mask);
    endfunction

    logic [SW-1:0] sync_level;
    logic [SW-1:0] sync_rise;
    logic [14:0]   fail_rise;
    logic [14:0]   qual_rise;
    logic          serial_q;
    logic          discard_q;

    // Flag and mask state
    logic [14:0] raw_r;
    logic [14:0] raw_nxt;
    logic [14:0] mask0_r;
    logic [14:0] mask0_nxt;
    logic [14:0] mask1_r;
    logic [14:0] mask1_nxt;
    logic [14:0] masked0_r;
    logic [14:0] masked1_r;

    // First-sync history
    logic [2:0]  first_seen_r;
    logic [2:0]  first_mark;

    // Interrupt wires
    logic [1:0]  soft_pend_r;
    logic [1:0]  wire_req;
    logic [1:0]  wire_pulse;

    // Event path and emulation
    logic [29:0] events_r;
    logic [29:0] events_nxt;
    logic [29:0] halt_sel;
    logic [29:0] force_bits;
    logic        susp_active;
    logic        halt_all;
    logic        halt_some;
    logic        partial_r;
    logic        timers_halt_r;

    fsec_fail_sync #(
        .W (SW)
    ) u_sync (
        .mclk     (mclk),
        .srst     (srst),
        .ce       (ce),
        .async_in ({msg_discarded, serial_sync_mode, fail_in}),
        .level    (sync_level),
        .rise     (sync_rise)
    );

    assign serial_q  = sync_level[FSEC_FAIL_W + FSEC_Q_SERIAL];
    assign discard_q = sync_level[FSEC_FAIL_W + FSEC_Q_DISCARD];
    assign fail_rise = sync_rise[FSEC_FAIL_W-1:0];

    // Qualifies each edge before it reaches a raw flag
    always_comb begin
        qual_rise = fail_rise;
        if (!serial_q) begin
            qual_rise = qual_rise & ~FSEC_SERIAL_ONLY;
        end

        if (discard_q) begin
            qual_rise = qual_rise & ~FSEC_KIND_BITS;
        end

        qual_rise[2:0] = qual_rise[2:0] & first_seen_r;

        // Wrap has no mode qualifier
        // wrap passes through
        qual_rise[FSEC_B_DAY_WRAP] = fail_rise[FSEC_B_DAY_WRAP];
    end

    // Bit 2 has a first sync only in serial mode
    assign first_mark = fail_rise[2:0] & FSEC_FIRST_EXCL[2:0] & {serial_q, 2'b11};

    // First resync edge per timer only marks it seen
    always_ff @(posedge mclk) begin
        if (srst) begin
            first_seen_r <= FSEC_SYNC_RST;
        end else if (ce) begin
            first_seen_r <= first_seen_r | first_mark;
        end
    end

    assign raw_nxt   = fsec_apply(raw_r, raw_cmd, qual_rise);
    assign mask0_nxt = fsec_apply(mask0_r, mask0_cmd, 15'h0000);
    assign mask1_nxt = fsec_apply(mask1_r, mask1_cmd, 15'h0000);

    always_ff @(posedge mclk) begin
        if (srst) begin
            raw_r <= FSEC_RAW_RST;
        end else if (ce) begin
            raw_r <= raw_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask0_r <= FSEC_MASK_RST;
            mask1_r <= FSEC_MASK_RST;
        end else if (ce) begin
            mask0_r <= mask0_nxt;
            mask1_r <= mask1_nxt;
        end
    end

    // Registered from next values so status matches raw_r
    always_ff @(posedge mclk) begin
        if (srst) begin
            masked0_r <= FSEC_RAW_RST;
            masked1_r <= FSEC_RAW_RST;
        end else if (ce) begin
            masked0_r <= raw_nxt & mask0_nxt;
            masked1_r <= raw_nxt & mask1_nxt;
        end
    end

    // A software request obeys the same blocking as a fail
    // set wins clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            soft_pend_r <= 2'h0;
        end else if (ce) begin
            soft_pend_r <= (soft_pend_r & ~int_clr) | int_set;
        end
    end

    // Registered state only, so a pulse follows visible status
    // OR per wire
    assign wire_req[0] = fsec_any_masked(raw_r, mask0_r) | soft_pend_r[0];
    assign wire_req[1] = fsec_any_masked(raw_r, mask1_r) | soft_pend_r[1];

    // Rearm while armed is ignored; a standing request pulses at once
    // pulse and block
    fsec_wire_pulser u_wire0 (
        .mclk  (mclk),
        .srst  (srst),
        .ce    (ce),
        .req   (wire_req[0]),
        .rearm (interrupt_rearm_register[0]),
        .pulse (wire_pulse[0])
    );

    fsec_wire_pulser u_wire1 (
        .mclk  (mclk),
        .srst  (srst),
        .ce    (ce),
        .req   (wire_req[1]),
        .rearm (interrupt_rearm_register[1]),
        .pulse (wire_pulse[1])
    );

    assign susp_active = debug_suspend_input & ~emulation_control_register.free_run;
    assign halt_all    = susp_active & emulation_control_register.soft_halt;
    assign halt_some   = susp_active & ~emulation_control_register.soft_halt;

    // Halted events are dropped, not deferred: a debugger sees no burst on resume
    always_comb begin
        halt_sel = FSEC_EVT_RST;
        if (halt_all) begin
            halt_sel = ~FSEC_EVT_RST;
        end else if (halt_some) begin
            halt_sel = emulation_event_mask;
        end
    end

    assign force_bits = event_force_register.wr ? event_force_register.bits : FSEC_EVT_RST;
    assign events_nxt = (gen_events | force_bits) & ~halt_sel;

    // Low ce stalls the flop, so a forced pulse stands until ce returns
    always_ff @(posedge mclk) begin
        if (srst) begin
            events_r <= FSEC_EVT_RST;
        end else if (ce) begin
            events_r <= events_nxt;
        end
    end

    // Indicators are registered and trail the gating by one cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            partial_r     <= 1'b0;
            timers_halt_r <= 1'b0;
        end else if (ce) begin
            partial_r     <= halt_some;
            timers_halt_r <= halt_all;
        end
    end

    // Outputs come straight from flops
    assign frame_events       = events_r;
    assign fail_wire          = wire_pulse;
    assign raw_fail_flags     = raw_r;
    assign masked_stat0       = masked0_r;
    assign masked_stat1       = masked1_r;
    assign mask0_state        = mask0_r;
    assign mask1_state        = mask1_r;
    assign int_pending        = soft_pend_r;
    assign partial_event_halt = partial_r;
    assign timers_halt        = timers_halt_r;
endmodule // fsec_event_error_ctrl
`default_nettype wire

/* inc/fsec_pkg.sv */
`default_nettype none
package fsec_pkg;
    // Widths
    localparam int FSEC_FAIL_W = 15;
    localparam int FSEC_EVT_W  = 30;
    localparam int FSEC_WIRES  = 2;
    localparam int FSEC_QUAL_W = 2;

    // Fail flag bit positions
    localparam int FSEC_B_SYS_RESYNC    = 0;
    localparam int FSEC_B_RADIO_RESYNC  = 1;
    localparam int FSEC_B_DAY_RESYNC    = 2;
    localparam int FSEC_B_SYS_TIMEOUT   = 3;
    localparam int FSEC_B_RADIO_TIMEOUT = 4;
    localparam int FSEC_B_DAY_TIMEOUT   = 5;
    localparam int FSEC_B_CHECKSUM      = 6;
    localparam int FSEC_B_BIT_WIDTH     = 7;
    localparam int FSEC_B_KIND_RSVD     = 8;
    localparam int FSEC_B_KIND_SPARE    = 9;
    localparam int FSEC_B_KIND_UNEXP    = 10;
    localparam int FSEC_B_KIND_DAY      = 11;
    localparam int FSEC_B_KIND_RADIO    = 12;
    localparam int FSEC_B_KIND_SYS      = 13;
    localparam int FSEC_B_DAY_WRAP      = 14;

    // Qualifier bits carried through the synchroniser
    localparam int FSEC_Q_SERIAL  = 0;
    localparam int FSEC_Q_DISCARD = 1;

    // Groups of fail bits
    localparam logic [14:0] FSEC_SERIAL_ONLY = 15'h3FFC;
    localparam logic [14:0] FSEC_KIND_BITS   = 15'h3F00;
    localparam logic [14:0] FSEC_FIRST_EXCL  = 15'h0007;

    // Reset values
    localparam logic [14:0] FSEC_RAW_RST  = 15'h0000;
    localparam logic [14:0] FSEC_MASK_RST = 15'h0000;
    localparam logic [29:0] FSEC_EVT_RST  = 30'h00000000;
    localparam logic [2:0]  FSEC_SYNC_RST = 3'h0;

    // Fail conditions, bit 14 down to bit 0
    typedef struct packed {
        logic daytime_counter_wrap;
        logic sys_kind_flag;
        logic radio_kind_flag;
        logic daytime_kind_flag;
        logic unexpected_kind_flag;
        logic spare_kind_flag;
        logic reserved_kind_flag;
        logic bit_width_fail;
        logic checksum_fail;
        logic daytime_update_timeout;
        logic radio_update_timeout;
        logic system_update_timeout;
        logic daytime_resync_flag;
        logic radio_resync_flag;
        logic system_resync_flag;
    } fsec_fail_t;

    // Set/clear command on a 15-bit flag group
    typedef struct packed {
        logic        set;
        logic        clr;
        logic [14:0] bits;
    } fsec_bitcmd_t;

    typedef struct packed {
        logic        wr;
        logic [29:0] bits;
    } fsec_force_t;

    typedef struct packed {
        logic free_run;
        logic soft_halt;
    } fsec_emu_t;
endpackage
`default_nettype wire

/* logic/fsec_fail_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module fsec_fail_sync import fsec_pkg::*; #(
    parameter int W = 17
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // Only sync_r reads meta_r
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
endmodule // fsec_fail_sync
`default_nettype wire

/* logic/fsec_wire_pulser.sv */
`timescale 1ns/10ps
`default_nettype none
module fsec_wire_pulser import fsec_pkg::*; (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic req,
    input  wire logic rearm,
    output logic      pulse
);
    typedef enum logic [1:0] {
        FSEC_ARMED   = 2'b01,
        FSEC_BLOCKED = 2'b10
    } fsec_wstate_t;

    fsec_wstate_t state_r;
    logic         pulse_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= FSEC_ARMED;
            pulse_r <= 1'b0;
        end else if (ce) begin
            pulse_r <= 1'b0;
            case (state_r)
                FSEC_ARMED: begin
                    if (req) begin
                        pulse_r <= 1'b1;
                        state_r <= FSEC_BLOCKED;
                    end
                end
                FSEC_BLOCKED: begin
                    if (rearm) begin
                        state_r <= FSEC_ARMED;
                    end
                end
                default: state_r <= FSEC_ARMED;
            endcase
        end
    end

    assign pulse = pulse_r;
endmodule // fsec_wire_pulser
`default_nettype wire

/* bench/fsec_event_error_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module fsec_event_error_ctrl_properties import fsec_pkg::*; (
    input wire logic         mclk,
    input wire logic         srst,
    input wire logic         ce,
    input wire fsec_fail_t   fail_in,
    input wire fsec_force_t  event_force_register,
    input wire fsec_bitcmd_t raw_cmd,
    input wire logic [1:0]   interrupt_rearm_register,
    input wire fsec_emu_t    emulation_control_register,
    input wire logic [29:0]  emulation_event_mask,
    input wire logic         debug_suspend_input,
    input wire logic [29:0]  frame_events,
    input wire logic [1:0]   fail_wire,
    input wire logic [14:0]  raw_fail_flags,
    input wire logic [14:0]  masked_stat0,
    input wire logic [14:0]  masked_stat1,
    input wire logic [14:0]  mask0_state,
    input wire logic [14:0]  mask1_state,
    input wire logic         partial_event_halt,
    input wire logic         timers_halt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !ce);

    a_masked_and: assert property (
        masked_stat0 == (raw_fail_flags & mask0_state)
        && masked_stat1 == (raw_fail_flags & mask1_state))
        else $error("masked status differs from raw and mask");
    a_wire_single: assert property (
        (fail_wire != 2'h0) |=> ((fail_wire & $past(fail_wire)) == 2'h0))
        else $error("fail wire pulse longer than one cycle");
    a_wire_blocked: assert property (
        fail_wire[0] ##1 !interrupt_rearm_register[0] [*2] |=> !fail_wire[0])
        else $error("fail wire pulsed again without rearm");
    a_force_pulse: assert property (
        event_force_register.wr && !debug_suspend_input |=>
        (frame_events & $past(event_force_register.bits)) == $past(event_force_register.bits))
        else $error("forced event missing");
    a_full_halt: assert property (
        debug_suspend_input && emulation_control_register.soft_halt
        && !emulation_control_register.free_run |=> frame_events == 30'h0)
        else $error("event leaked during full halt");
    a_partial_halt: assert property (
        debug_suspend_input && !emulation_control_register.soft_halt
        && !emulation_control_register.free_run |=>
        (frame_events & $past(emulation_event_mask)) == 30'h0)
        else $error("masked event leaked during partial halt");
    a_free_run: assert property (
        emulation_control_register.free_run |=> !timers_halt && !partial_event_halt)
        else $error("halt indicated in free run");
    a_raw_set: assert property (
        raw_cmd.set |=> (raw_fail_flags & $past(raw_cmd.bits)) == $past(raw_cmd.bits))
        else $error("raw flag set command lost");
    a_sync_edge: assert property (
        !fail_in.daytime_counter_wrap ##1 fail_in.daytime_counter_wrap [*4]
        |=> raw_fail_flags[14])
        else $error("rising fail input did not set flag");
endmodule // fsec_event_error_ctrl_properties
`default_nettype wire

/* bench/fsec_irq_sink.sv */
`timescale 1ns/10ps
`default_nettype none
// Stands in for the interrupt controllers: every high cycle is one event
module fsec_irq_sink import fsec_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [29:0] frame_events,
    input  wire logic [1:0]  fail_wire,
    output logic      [7:0]  wire_cnt0,
    output logic      [7:0]  wire_cnt1,
    output logic      [7:0]  evt_cnt
);
    always_ff @(posedge mclk) begin
        if (srst) begin
            wire_cnt0 <= 8'h00;
            wire_cnt1 <= 8'h00;
            evt_cnt   <= 8'h00;
        end else begin
            wire_cnt0 <= wire_cnt0 + {7'h00, fail_wire[0]};
            wire_cnt1 <= wire_cnt1 + {7'h00, fail_wire[1]};
            evt_cnt   <= evt_cnt + {7'h00, |frame_events};
        end
    end
endmodule // fsec_irq_sink
`default_nettype wire

/* bench/test_frame_sync_event_error_control.sv */
`timescale 1ns/10ps
`default_nettype none
module test_frame_sync_event_error_control import fsec_pkg::*;;
    logic mclk, srst, ce, ser, dis, dbg, peh, th;
    logic [14:0] fin, raw, ms0, ms1, mk0, mk1;
    logic [29:0] gen, emask, fev;
    logic [1:0] rearm, iset, iclr, fw, ipend;
    logic [7:0] wc0, wc1, ec;
    fsec_force_t frc;
    fsec_bitcmd_t rc, m0, m1;
    fsec_emu_t emu;
    int err_count, cmp_count, cyc;
    // {index, serial, discard, expected flag}
    logic [7:0] tbl [21] = '{8'h04, 8'h05, 8'h08, 8'h09, 8'h10, 8'h14, 8'h15, 8'h18,
        8'h1D, 8'h30, 8'h35, 8'h3D, 8'h46, 8'h45, 8'h4E, 8'h4D, 8'h55, 8'h5E, 8'h60,
        8'h6D, 8'h73};

    fsec_event_error_ctrl uut (.mclk(mclk), .srst(srst), .ce(ce), .fail_in(fin),
        .serial_sync_mode(ser), .msg_discarded(dis), .gen_events(gen),
        .event_force_register(frc), .raw_cmd(rc), .mask0_cmd(m0), .mask1_cmd(m1),
        .interrupt_rearm_register(rearm), .int_set(iset), .int_clr(iclr),
        .emulation_control_register(emu), .emulation_event_mask(emask),
        .debug_suspend_input(dbg), .frame_events(fev), .fail_wire(fw),
        .raw_fail_flags(raw), .masked_stat0(ms0), .masked_stat1(ms1), .mask0_state(mk0),
        .mask1_state(mk1), .int_pending(ipend), .partial_event_halt(peh),
        .timers_halt(th));
    fsec_irq_sink u_sink (.mclk(mclk), .srst(srst), .frame_events(fev), .fail_wire(fw),
        .wire_cnt0(wc0), .wire_cnt1(wc1), .evt_cnt(ec));

    always #50 mclk = ~mclk;

    task tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task chk(input string nm, input logic [29:0] e, input logic [29:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // w: 0 raw flags, 1 mask0, 2 mask1
    task cmd(input int w, input logic s, input logic c, input logic [14:0] b);
        fsec_bitcmd_t x;
        x = '{s, c, b};
        if (w == 0) rc = x;
        else if (w == 1) m0 = x;
        else m1 = x;
        tick(1);
        rc = '0;
        m0 = '0;
        m1 = '0;
        tick(1);
    endtask
    // k: 0 rearm, 1 set pending, 2 clear pending
    task strobe(input int k, input logic [1:0] v);
        if (k == 0) rearm = v;
        else if (k == 1) iset = v;
        else iclr = v;
        tick(1);
        rearm = 2'h0;
        iset = 2'h0;
        iclr = 2'h0;
        tick(1);
    endtask
    task evt(input logic [29:0] f, input logic [29:0] g, input logic [29:0] e);
        frc = '{1'b1, f};
        gen = g;
        tick(1);
        frc = '0;
        gen = 30'h0;
        chk("frame_events", e, fev);
        tick(1);
        chk("frame_events idle", 30'h0, fev);
    endtask
    task fail_pulse(input int b);
        tick(3);
        fin[b] = 1'b1;
        tick(6);
        fin = 15'h0;
        tick(3);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        // Run needs about 460 cycles
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        mclk = 1'b0; srst = 1'b1; ce = 1'b1; ser = 1'b0; dis = 1'b0; dbg = 1'b0;
        fin = 15'h0; gen = 30'h0; emask = 30'h0; rearm = 2'h0; iset = 2'h0;
        iclr = 2'h0; frc = '0; rc = '0; m0 = '0; m1 = '0; emu = '0;
        err_count = 0; cmp_count = 0; cyc = 0;
        tick(2);
        srst = 1'b0;
        tick(1);
        chk("raw reset", 30'h0, {15'h0, raw});
        chk("mask0 reset", 30'h0, {15'h0, mk0});
        foreach (tbl[i]) begin
            ser = tbl[i][2];
            dis = tbl[i][1];
            tick(3);
            fin[tbl[i][7:3]] = 1'b1;
            tick(6);
            fin = 15'h0;
            tick(3);
            chk("raw flag", {29'h0, tbl[i][0]}, {29'h0, raw[tbl[i][7:3]]});
            cmd(0, 1'b0, 1'b1, 15'h7FFF);
        end
        cmd(1, 1'b1, 1'b0, 15'h0030);
        cmd(2, 1'b1, 1'b0, 15'h0200);
        chk("mask0", 30'h30, {15'h0, mk0});
        chk("mask1", 30'h200, {15'h0, mk1});
        cmd(0, 1'b1, 1'b0, 15'h0010);
        tick(3);
        chk("masked0", 30'h10, {15'h0, ms0});
        chk("wire0 count", 30'h1, {22'h0, wc0});
        chk("wire1 count", 30'h0, {22'h0, wc1});
        cmd(0, 1'b1, 1'b0, 15'h0020);
        tick(3);
        chk("wire0 blocked", 30'h1, {22'h0, wc0});
        strobe(0, 2'h1);
        tick(3);
        chk("wire0 rearmed", 30'h2, {22'h0, wc0});
        cmd(0, 1'b0, 1'b1, 15'h7FFF);
        strobe(0, 2'h1);
        tick(3);
        chk("wire0 idle", 30'h2, {22'h0, wc0});
        cmd(0, 1'b1, 1'b0, 15'h0200);
        tick(3);
        chk("wire1 count", 30'h1, {22'h0, wc1});
        cmd(2, 1'b0, 1'b1, 15'h7FFF);
        chk("mask1 clear", 30'h0, {15'h0, ms1});
        strobe(0, 2'h2);
        tick(3);
        chk("wire1 masked", 30'h1, {22'h0, wc1});
        strobe(1, 2'h2);
        tick(3);
        chk("pending", 30'h2, {28'h0, ipend});
        chk("wire1 set", 30'h2, {22'h0, wc1});
        strobe(2, 2'h2);
        strobe(0, 2'h2);
        tick(3);
        chk("pending clr", 30'h0, {28'h0, ipend});
        chk("wire1 after clr", 30'h2, {22'h0, wc1});
        // no timer arm input here; forced events need none
        for (int i = 0; i < 30; i++) evt(30'h1 << i, 30'h0, 30'h1 << i);
        evt(30'h1, 30'h20000000, 30'h20000001);
        dbg = 1'b1;
        emask = 30'h1;
        tick(2);
        chk("partial halt", 30'h1, {29'h0, peh});
        evt(30'h3, 30'h0, 30'h2);
        emu = '{1'b0, 1'b1};
        tick(2);
        chk("timers halt", 30'h1, {29'h0, th});
        evt(30'h3, 30'h0, 30'h0);
        emu = '{1'b1, 1'b1};
        tick(2);
        chk("free halt", 30'h0, {28'h0, th, peh});
        evt(30'h3, 30'h0, 30'h3);
        chk("event count", 30'h21, {22'h0, ec});
        emu = '{1'b1, 1'b0};
        tick(2);
        chk("free soft0 halt", 30'h0, {28'h0, th, peh});
        evt(30'h3, 30'h0, 30'h3);
        dbg = 1'b0;
        emu = '0;
        ser = 1'b1;
        dis = 1'b0;
        // Second reset must forget the first-sync history
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(1);
        chk("raw after reset", 30'h0, {15'h0, raw});
        chk("mask0 after reset", 30'h0, {15'h0, mk0});
        fail_pulse(FSEC_B_SYS_RESYNC);
        chk("first sync after reset", 30'h0, {29'h0, raw[0]});
        fail_pulse(FSEC_B_SYS_RESYNC);
        chk("resync after reset", 30'h1, {29'h0, raw[0]});
        // Low ce freezes every flop of the uut
        ce = 1'b0;
        cmd(0, 1'b1, 1'b0, 15'h4000);
        evt(30'h1, 30'h0, 30'h0);
        chk("raw frozen", 30'h0, {29'h0, raw[14]});
        ce = 1'b1;
        cmd(0, 1'b1, 1'b0, 15'h4000);
        chk("raw set after freeze", 30'h1, {29'h0, raw[14]});
        results();
    end
endmodule // test_frame_sync_event_error_control

bind fsec_event_error_ctrl fsec_event_error_ctrl_properties u_chk (.mclk(mclk),
    .srst(srst), .ce(ce), .fail_in(fail_in), .event_force_register(event_force_register),
    .raw_cmd(raw_cmd), .interrupt_rearm_register(interrupt_rearm_register),
    .emulation_control_register(emulation_control_register),
    .emulation_event_mask(emulation_event_mask), .debug_suspend_input(debug_suspend_input),
    .frame_events(frame_events), .fail_wire(fail_wire), .raw_fail_flags(raw_fail_flags),
    .masked_stat0(masked_stat0), .masked_stat1(masked_stat1), .mask0_state(mask0_state),
    .mask1_state(mask1_state), .partial_event_halt(partial_event_halt),
    .timers_halt(timers_halt));
`default_nettype wire
